/* File: sio_buf_defines.vh */
// What this block does
// - Serial out enable drives the data pin, open-drain only in pin set B, ignoring the port latch.
// - Mode bit 7 gates the overrun flag onto the interrupt request.
// - Mode bit 6 gates the empty flag onto the interrupt request.
// - Mode bit 5 gates the full flag onto the interrupt request.
// - Mode bit 4 hands the data output pin to the serial channel.
// - With shift enable set, a transmit buffer write starts shifting.
// - Clearing shift enable halts shifting and returns all flags to initial values.
// - Non-external clock codes pick an internal clock driven out on the clock pin.
// - Code 00 takes the shift clock from the clock pin when it is an input.
// - Bit order select zero shifts LSB first, one shifts MSB first.
// - Transmit and receive buffers share one address; writes transmit, reads receive.
// - Shift counter overflows after eight shifts, timing buffer loads and flags.
// - Full flag set while unread receive data waits; a buffer read clears it.
// - Empty flag is one while no byte waits to transmit; a write while shifting clears it.
// - Overrun sets on reload over unread data; write zero clears, one ignored.
`ifndef SIO_BUF_DEFINES_VH
`define SIO_BUF_DEFINES_VH
`define ADDR_MODE 16'h0022
`define ADDR_FLAGS 16'h0023
`define ADDR_BUF 16'h0024
`define ADDR_SHIFT 16'h0025
`define MODE_RESET 8'h00
`define MODE_OVE 7
`define MODE_EME 6
`define MODE_FLE 5
`define MODE_SOE 4
`define MODE_SEN 3
`define MODE_CKS_HI 2
`define MODE_CKS_LO 1
`define MODE_BDS 0
`define FLAG_OVF 2
`define FLAG_EMF 1
`define FLAG_FLF 0
`define CKS_EXT 2'h0
`define CKS_DIV2 2'h1
`define CKS_DIV8 2'h2
`define CKS_DIV32 2'h3
`define INST_CYCLES 8
`define HALF_DIV2 8'h02
`define HALF_DIV8 8'h08
`define HALF_DIV32 8'h20
`define SHIFT_BITS 4'h8
`endif

/* File: sio_pin_sync.v */
`timescale 1ns/1ps
module sio_pin_sync (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Raw pin and filtered level
  input wire pin_in,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s2_q;
    end
  end
endmodule // sio_pin_sync

/* File: sio_buf_core.v */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "sio_buf_defines.vh"
module sio_buf_core (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  // Port settings from the pin set in use
  input wire pin_set_b,
  input wire port6_direction,
  input wire port7_latch,
  input wire port_out_value,
  // Shift clock pin
  input wire shift_clock_in,
  output reg shift_clock_out_q,
  output reg shift_clock_oe_q,
  // Data pins
  input wire serial_in,
  output reg serial_out_q,
  output reg serial_out_oe_q,
  // Interrupt request
  output reg serial_irq_line_q
);
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] mode_q;
  reg ovf_q;
  reg emf_q;
  reg flf_q;
  reg [7:0] shift_q;
  reg [7:0] txbuf_q;
  reg [7:0] rxbuf_q;
  reg [3:0] count_q;
  reg busy_q;
  reg [7:0] div_q;
  reg int_clk_q;
  reg ext_clk_q;
  reg out_bit_q;
  wire ext_clk;
  wire shift_enable = mode_q[`MODE_SEN];
  wire bit_order_select = mode_q[`MODE_BDS];
  wire [1:0] cks = mode_q[`MODE_CKS_HI:`MODE_CKS_LO];
  wire ext_mode = (cks == `CKS_EXT);
  wire wr_mode = reg_wr && (reg_addr == `ADDR_MODE);
  wire wr_flags = reg_wr && (reg_addr == `ADDR_FLAGS);
  wire wr_buf = reg_wr && (reg_addr == `ADDR_BUF);
  wire rd_buf = reg_rd && (reg_addr == `ADDR_BUF);
  reg [7:0] half_sel;
  // Half period in core clocks, cut to the divider width
  wire [31:0] reload_full = half_sel * `INST_CYCLES / 2;
  wire [7:0] reload = reload_full[7:0];

  sio_pin_sync clk_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin_in(shift_clock_in),
    .level_q(ext_clk)
  );

  reg [2:0] din_s_q;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      din_s_q <= 3'h0;
    else
      din_s_q <= {din_s_q[1:0], serial_in};
  end
  reg din_q;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      din_q <= 1'b0;
    else if (din_s_q[1] == din_s_q[2])
      din_q <= din_s_q[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock divider, full periods in instruction cycles
  always @*
  begin
    case (cks)
      `CKS_DIV2: half_sel = `HALF_DIV2;
      `CKS_DIV8: half_sel = `HALF_DIV8;
      `CKS_DIV32: half_sel = `HALF_DIV32;
      default: half_sel = 8'h01;
    endcase
  end

  // External pin usable only when configured as input
  wire ext_ok = pin_set_b ? port7_latch : !port6_direction;
  wire int_tick = (div_q == 8'h01);
  wire int_fall = busy_q && !ext_mode && int_tick && int_clk_q;
  wire int_rise = busy_q && !ext_mode && int_tick && !int_clk_q;
  wire ext_fall = busy_q && ext_mode && ext_ok && ext_clk_q && !ext_clk;
  wire ext_rise = busy_q && ext_mode && ext_ok && !ext_clk_q && ext_clk;
  wire fall = int_fall || ext_fall;
  wire rise = int_rise || ext_rise;
  wire last = rise && (count_q == `SHIFT_BITS - 4'h1);
  wire [7:0] rx_byte = bit_order_select ? {shift_q[6:0], din_q} : {din_q, shift_q[7:1]};

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q <= 8'h01;
      int_clk_q <= 1'b1;
      ext_clk_q <= 1'b1;
    end
    else
    begin
      ext_clk_q <= ext_clk;
      if (!busy_q)
      begin
        div_q <= reload;
        int_clk_q <= 1'b1;
      end
      else if (int_tick)
      begin
        div_q <= reload;
        int_clk_q <= !int_clk_q;
      end
      else
        div_q <= div_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, shift engine and flags
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q <= `MODE_RESET;
      ovf_q <= 1'b0;
      emf_q <= 1'b1;
      flf_q <= 1'b0;
      shift_q <= 8'h00;
      txbuf_q <= 8'h00;
      rxbuf_q <= 8'h00;
      count_q <= 4'h0;
      busy_q <= 1'b0;
      out_bit_q <= 1'b1;
    end
    else
    begin
      if (wr_mode)
        mode_q <= reg_wdata;
      if (wr_buf)
      begin
        txbuf_q <= reg_wdata;
        emf_q <= 1'b0;
      end
      if (rd_buf)
        flf_q <= 1'b0;
      if (wr_flags && !reg_wdata[`FLAG_OVF])
        ovf_q <= 1'b0;
      if (!busy_q && shift_enable && (wr_buf || !emf_q))
      begin
        shift_q <= wr_buf ? reg_wdata : txbuf_q;
        busy_q <= 1'b1;
        count_q <= 4'h0;
        emf_q <= 1'b1;
        out_bit_q <= bit_order_select ? (wr_buf ? reg_wdata[7] : txbuf_q[7]) : (wr_buf ? reg_wdata[0] : txbuf_q[0]);
      end
      else if (busy_q)
      begin
        // Every fall, so a reloaded byte shows its first bit too
        if (fall)
          out_bit_q <= bit_order_select ? shift_q[7] : shift_q[0];
        if (rise)
        begin
          shift_q <= rx_byte;
          count_q <= count_q + 4'h1;
        end
        if (last)
        begin
          rxbuf_q <= rx_byte;
          flf_q <= 1'b1;
          if (flf_q && !rd_buf)
            ovf_q <= 1'b1;
          if (!emf_q && !wr_buf)
          begin
            shift_q <= txbuf_q;
            count_q <= 4'h0;
            emf_q <= 1'b1;
          end
          else if (wr_buf)
          begin
            shift_q <= reg_wdata;
            count_q <= 4'h0;
            emf_q <= 1'b1;
          end
          else
            busy_q <= 1'b0;
        end
      end
      if (!shift_enable || (wr_mode && !reg_wdata[`MODE_SEN]))
      begin
        busy_q <= 1'b0;
        count_q <= 4'h0;
        ovf_q <= 1'b0;
        emf_q <= 1'b1;
        flf_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins, read data, interrupt
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_clock_out_q <= 1'b1;
      shift_clock_oe_q <= 1'b0;
      serial_out_q <= 1'b1;
      serial_out_oe_q <= 1'b0;
      serial_irq_line_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      shift_clock_out_q <= int_clk_q;
      shift_clock_oe_q <= !ext_mode && (!pin_set_b || !int_clk_q);
      if (mode_q[`MODE_SOE])
      begin
        serial_out_q <= out_bit_q;
        serial_out_oe_q <= pin_set_b ? !out_bit_q : 1'b1;
      end
      else
      begin
        serial_out_q <= port_out_value;
        serial_out_oe_q <= pin_set_b ? !port_out_value : 1'b0;
      end
      serial_irq_line_q <= (mode_q[`MODE_OVE] && ovf_q) ||
        (mode_q[`MODE_EME] && emf_q) ||
        (mode_q[`MODE_FLE] && flf_q);
      reg_rdata_q <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `ADDR_MODE: reg_rdata_q <= mode_q;
          `ADDR_FLAGS: reg_rdata_q <= {5'h00, ovf_q, emf_q, flf_q};
          `ADDR_BUF: reg_rdata_q <= rxbuf_q;
          `ADDR_SHIFT: reg_rdata_q <= shift_q;
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end
endmodule // sio_buf_core

/* File: sio_buf_chk_asserts.sv */
`timescale 1ns/1ps
module sio_buf_chk (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  // Pins
  input wire pin_set_b,
  input wire shift_clock_out_q,
  input wire shift_clock_oe_q,
  input wire serial_out_q,
  input wire serial_out_oe_q,
  input wire serial_irq_line_q
);
  reg [7:0] mode_q;
  // Shadow of the mode register
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      mode_q <= 8'h00;
    else if (reg_wr && reg_addr == 16'h0022)
      mode_q <= reg_wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_rd_idle; !reg_rd |=> reg_rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_mode_rb; reg_rd && reg_addr == 16'h0022 |=> reg_rdata_q == $past(mode_q); endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
  property p_ext_oe; (mode_q[2:1] == 2'h0)[*3] |-> !shift_clock_oe_q; endproperty
  a_ext_oe: assert property (p_ext_oe) else $error("clock driven in ext mode");
  property p_halt; (!mode_q[3])[*3] |-> $stable(shift_clock_out_q); endproperty
  a_halt: assert property (p_halt) else $error("clock moves while halted");
  property p_irq_off; (mode_q[7:5] == 3'h0)[*3] |-> !serial_irq_line_q; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enable");
  property p_emp; (mode_q[6] && !mode_q[3])[*3] |-> serial_irq_line_q; endproperty
  a_emp: assert property (p_emp) else $error("empty irq missing");
  property p_od; $past(pin_set_b) && serial_out_oe_q |-> !serial_out_q; endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_div2; $fell(shift_clock_out_q) && mode_q[2:1] == 2'h1 |=> (!shift_clock_out_q)[*7] ##1 shift_clock_out_q;
  endproperty
  a_div2: assert property (p_div2) else $error("div2 half period");
endmodule // sio_buf_chk

/* File: sio_peer.sv */
`timescale 1ns/1ps
module sio_peer (
  // Link pins
  input wire sck,
  input wire sdi,
  output reg sdo,
  output reg ck_gen,
  // Bench control
  input wire load,
  input wire msb,
  input wire [7:0] tx,
  output reg [7:0] rx
);
  reg [7:0] sh;
  initial
  begin
    sdo = 1'h1;
    ck_gen = 1'h1;
  end
  // External clock, idle high between frames
  task run_clock;
    repeat (8)
    begin
      #80 ck_gen = 1'h0;
      #80 ck_gen = 1'h1;
    end
  endtask
  always @(posedge load)
    sh = tx;
  always @(negedge sck)
  begin
    sdo = msb ? sh[7] : sh[0];
    sh = msb ? sh << 1 : sh >> 1;
  end
  always @(posedge sck)
    rx = msb ? {rx[6:0], sdi} : {sdi, rx[7:1]};
endmodule // sio_peer

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  reg core_clk, reset_n, reg_wr, reg_rd, pin_set_b, port6_direction, port7_latch, port_out_value, load, msb;
  reg [15:0] reg_addr;
  reg [7:0] reg_wdata, tx, d, b;
  wire [7:0] reg_rdata_q, rx;
  wire sck_out, sck_oe, so, so_oe, irq, ck_gen, sdo, sck, sdi;
  integer errors = 0, compares = 0, cyc = 0, i, n, seed;
  assign sck = sck_oe ? sck_out : ck_gen;
  assign sdi = so_oe ? so : 1'h1;
  sio_buf_core sio_buf_core_inst (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .pin_set_b, .port6_direction, .port7_latch, .port_out_value, .shift_clock_in(sck), .shift_clock_out_q(sck_out),
    .shift_clock_oe_q(sck_oe), .serial_in(sdo), .serial_out_q(so), .serial_out_oe_q(so_oe), .serial_irq_line_q(irq));
  sio_peer sio_peer_inst (.sck, .sdi, .sdo, .ck_gen, .load, .msb, .tx, .rx);
  function [7:0] fx(input o, input e, input f);
    fx = {5'h00, o, e, f};
  endfunction
  task wr(input [15:0] a, input [7:0] v);
  begin
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  end
  endtask
  task rd(input [15:0] a);
  begin
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata_q;
  end
  endtask
  task wait_flag(input [7:0] m);
  begin
    n = 0;
    rd(16'h0023);
    while ((d & m) == 8'h00 && n < 1500)
    begin
      rd(16'h0023);
      n++;
    end
  end
  endtask
  task give_verdict;
  begin
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict;
    end
  end
  initial
  begin
    seed = 32'h5e150bda;
    {reg_wr, reg_rd, load, msb, pin_set_b, port_out_value, reset_n} = 7'h00;
    port6_direction = 1'h0;
    port7_latch = 1'h1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    tx = 8'h00;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    rd(16'h0022); `CHK(d, 8'h00)
    rd(16'h0023); `CHK(d, fx(0, 1, 0))
    rd(16'h0030); `CHK(d, 8'h00)
    wr(16'h0022, 8'hA5);
    rd(16'h0022); `CHK(d, 8'hA5)
    for (i = 0; i < 16; i++)
    begin
      b = $random(seed);
      tx = $random(seed);
      msb = i[0];
      pin_set_b <= i[3];
      port_out_value <= $random(seed);
      load = 1'h1;
      #1 load = 1'h0;
      wr(16'h0022, {5'h07, i[2:1], i[0]});
      wr(16'h0024, b);
      if (i[2:1] == 2'h0)
        sio_peer_inst.run_clock;
      wait_flag(8'h01);
      `CHK(d, fx(0, 1, 1))
      `CHK(irq, 1'h1)
      rd(16'h0024); `CHK(d, tx)
      `CHK(rx, b)
      rd(16'h0023); `CHK(d, fx(0, 1, 0))
    end
    pin_set_b <= 1'h0;
    wr(16'h0022, 8'h1A);
    wr(16'h0024, 8'h3C);
    wait_flag(8'h01);
    wr(16'h0024, 8'hC3);
    wait_flag(8'h04);
    `CHK(d, fx(1, 1, 1))
    wr(16'h0023, 8'h04);
    rd(16'h0023); `CHK(d, fx(1, 1, 1))
    wr(16'h0022, 8'h9A);
    rd(16'h0023); `CHK(irq, 1'h1)
    wr(16'h0023, 8'h00);
    rd(16'h0023); `CHK(d, fx(0, 1, 1))
    `CHK(irq, 1'h0)
    wr(16'h0022, 8'h50);
    rd(16'h0023); `CHK(d, fx(0, 1, 0))
    `CHK(irq, 1'h1)
    wr(16'h0022, 8'h00);
    rd(16'h0023); `CHK(irq, 1'h0)
    give_verdict;
  end
endmodule // tb
bind sio_buf_core sio_buf_chk sio_buf_chk_inst (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_q, .pin_set_b, .shift_clock_out_q, .shift_clock_oe_q, .serial_out_q, .serial_out_oe_q, .serial_irq_line_q);
